// >>> exec_data_ram.sv
// Purpose: data memory, registered read
// Assumes: no same-word read and write
// Notes:   contents not reset
`timescale 1ns/100ps
`default_nettype none
module exec_data_ram
  import mcu_exec_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic [RAM_AW-1:0]   rdAddr,
  output logic      [DATA_W-1:0]   rdData,
  input  wire logic                wrEn,
  input  wire logic [RAM_AW-1:0]   wrAddr,
  input  wire logic [DATA_W-1:0]   wrData
);
  logic [DATA_W-1:0] memArray [0:(1<<RAM_AW)-1];

  // array write, no reset so it maps to a RAM macro
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      memArray[wrAddr] <= wrData;
    end
  end

  // read data always comes out of a flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdData <= BYTE_ZERO;
    end else begin
      rdData <= memArray[rdAddr];
    end
  end
endmodule
`default_nettype wire

// >>> exec_stack.sv
// Purpose: return stack, registered top
// Assumes: no push with pop
// Notes:   overflow wraps
`timescale 1ns/100ps
`default_nettype none
module exec_stack
  import mcu_exec_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              push,
  input  wire logic              pop,
  input  wire logic [PC_W-1:0]   pushData,
  output logic      [PC_W-1:0]   top
);
  logic [PC_W-1:0]     entry_reg [0:STACK_DEPTH-1];
  logic [STACK_PW-1:0] ptr_reg;
  logic [STACK_PW-1:0] ptr_next;
  logic [PC_W-1:0]     top_next;

  // top kept in a flop so a pop has no read delay
  always_comb begin
    ptr_next = ptr_reg;
    top_next = top;
    if (push) begin
      ptr_next = ptr_reg + PTR_ONE;
      top_next = pushData;
    end else if (pop) begin
      ptr_next = ptr_reg - PTR_ONE;
      top_next = entry_reg[ptr_reg - PTR_TWO];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_reg <= '0;
      top     <= PC_RESET;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        entry_reg[i] <= PC_RESET;
      end
    end else begin
      ptr_reg <= ptr_next;
      top     <= top_next;
      if (push) begin
        entry_reg[ptr_reg] <= pushData;
      end
    end
  end
endmodule
`default_nettype wire

// >>> irq_source_model.sv
// Purpose: pending interrupt source
// Assumes: core clock domain
// Notes:   held until acknowledged
`timescale 1ns/100ps
`default_nettype none
module irq_source_model (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic raise,
  input  wire logic intAck,
  output logic      intPending
);
  logic pending_reg;
  logic pending_next;
  always_comb begin
    pending_next = pending_reg;
    if (raise) begin
      pending_next = 1'b1;
    end else if (intAck) begin
      pending_next = 1'b0;
    end
  end
  // only register here, so the request lands one edge after raise
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= pending_next;
    end
  end
  assign intPending = pending_reg;
endmodule
`default_nettype wire

// >>> mcu_exec_pkg.sv
// Purpose: execute subset constants
// Assumes: 8-bit data, 11-bit pc
// Notes:   opcode codes are local
package mcu_exec_pkg;

  localparam int DATA_W      = 8;
  localparam int PC_W        = 11;
  localparam int RAM_AW      = 8;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PW    = 3;
  localparam int BIT_SEL_W   = 3;
  localparam int MSB         = DATA_W - 1;
  localparam int NIB         = 4;

  // clock figures: one instruction cycle is two core clocks at 200 MHz
  localparam int CLK_PERIOD_PS      = 5000;
  localparam int INSTR_CYCLE_PS     = 10000;
  localparam int CLOCKS_PER_INSTR   = INSTR_CYCLE_PS / CLK_PERIOD_PS;

  localparam logic [PC_W-1:0]   PC_RESET      = 11'h000;
  localparam logic [PC_W-1:0]   INT_VECTOR    = 11'h004;
  localparam logic [PC_W-1:0]   PC_STEP       = 11'h001;
  localparam logic [PC_W-1:0]   PC_SKIP_STEP  = 11'h002;
  localparam logic [DATA_W-1:0] BYTE_ZERO     = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE      = 8'h01;
  localparam logic [DATA_W-1:0] BYTE_ALL_ONES = 8'hFF;
  localparam logic [STACK_PW-1:0] PTR_ONE     = 3'h1;
  localparam logic [STACK_PW-1:0] PTR_TWO     = 3'h2;

  typedef enum logic [4:0] {
    OP_IDLE_CYCLE                    = 5'h00,
    OP_INCREMENT_TO_ACC              = 5'h01,
    OP_JUMP_ABSOLUTE                 = 5'h02,
    OP_COPY_MEM_TO_ACC               = 5'h03,
    OP_COPY_IMM_TO_ACC               = 5'h04,
    OP_COPY_ACC_TO_MEM               = 5'h05,
    OP_OR_MEM_TO_ACC                 = 5'h06,
    OP_OR_IMM_TO_ACC                 = 5'h07,
    OP_DISJUNCTION_INTO_RAM          = 5'h08,
    OP_SUBROUTINE_EXIT               = 5'h09,
    OP_SUBROUTINE_EXIT_IMM           = 5'h0A,
    OP_INTERRUPT_EXIT                = 5'h0B,
    OP_ROTATE_LEFT_IN_PLACE          = 5'h0C,
    OP_ROTATE_LEFT_TO_ACC            = 5'h0D,
    OP_CARRY_ROTATE_LEFT             = 5'h0E,
    OP_CARRY_ROTATE_LEFT_TO_ACC      = 5'h0F,
    OP_ROTATE_RIGHT_IN_PLACE         = 5'h10,
    OP_ROTATE_RIGHT_TO_ACC           = 5'h11,
    OP_CARRY_ROTATE_RIGHT            = 5'h12,
    OP_CARRY_ROTATE_RIGHT_TO_ACC     = 5'h13,
    OP_BORROW_SUBTRACT               = 5'h14,
    OP_BORROW_SUBTRACT_TO_RAM        = 5'h15,
    OP_DECREMENT_SKIP_IF_ZERO        = 5'h16,
    OP_DECREMENT_SKIP_IF_ZERO_TO_ACC = 5'h17,
    OP_INCREMENT_SKIP_IF_ZERO        = 5'h18,
    OP_INCREMENT_SKIP_IF_ZERO_TO_ACC = 5'h19,
    OP_SET_BYTE                      = 5'h1A,
    OP_SET_BIT                       = 5'h1B
  } op_type;

  typedef enum logic [1:0] {
    S_READY   = 2'b00,
    S_EXEC    = 2'b01,
    S_DUMMY_A = 2'b10,
    S_DUMMY_B = 2'b11
  } state_type;

endpackage

// >>> mcu_exec_subset_asserts.sv
// Purpose: port timing and result checks
// Assumes: results two edges after take
// Notes:   memory not visible here
`timescale 1ns/100ps
`default_nettype none
module exec_subset_asserts
  import mcu_exec_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  instrValid,
  input  wire logic                  instrReady,
  input  wire mcu_exec_pkg::op_type  instrOp,
  input  wire logic [DATA_W-1:0]     instrImm,
  input  wire logic [PC_W-1:0]       instrTarget,
  input  wire logic                  intPending,
  input  wire logic                  intAck,
  input  wire logic [PC_W-1:0]       pc,
  input  wire logic [DATA_W-1:0]     acc,
  input  wire logic                  carryFlag,
  input  wire logic                  zeroFlag,
  input  wire logic                  globalInterruptEnable
);
  logic keepOp;
  logic plainOp;
  // flag-neutral single-cycle forms
  assign keepOp = instrOp inside {OP_IDLE_CYCLE, [OP_COPY_MEM_TO_ACC:OP_COPY_ACC_TO_MEM],
                                  OP_SET_BYTE, OP_SET_BIT};
  assign plainOp = keepOp || instrOp == OP_OR_IMM_TO_ACC;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_take;
    instrValid && instrReady;
  endsequence
  // interrupt entry may take the ready slot
  sequence s_branch_gap;
    !instrReady [*3] ##1 (instrReady || intAck);
  endsequence
  a_take_goes_busy: assert property (s_take |=> !instrReady)
    else $error("ready after take");
  a_plain_one_cycle: assert property (s_take ##0 plainOp |=> !instrReady ##1 (instrReady || intAck))
    else $error("plain op length");
  a_plain_pc_step: assert property (s_take ##0 plainOp |=> ##1 pc == $past(pc, 2) + PC_STEP)
    else $error("pc did not step by one");
  a_jump_two_cycles: assert property (s_take ##0 instrOp == OP_JUMP_ABSOLUTE |=> s_branch_gap)
    else $error("jump not two cycles");
  a_jump_target_load: assert property (s_take ##0 instrOp == OP_JUMP_ABSOLUTE |=> ##1 pc == $past(instrTarget, 2))
    else $error("jump target not loaded");
  a_flags_kept: assert property (s_take ##0 (keepOp || instrOp == OP_JUMP_ABSOLUTE) |=> ##1
      carryFlag == $past(carryFlag, 2) && zeroFlag == $past(zeroFlag, 2))
    else $error("flag changed");
  a_imm_copy_acc: assert property (s_take ##0 instrOp == OP_COPY_IMM_TO_ACC |=> ##1 acc == $past(instrImm, 2))
    else $error("immediate copy wrong");
  a_or_imm_zero: assert property (s_take ##0 instrOp == OP_OR_IMM_TO_ACC |=> ##1
      acc == ($past(acc, 2) | $past(instrImm, 2)) && zeroFlag == (acc == BYTE_ZERO))
    else $error("or immediate wrong");
  a_exit_imm_acc: assert property (s_take ##0 instrOp == OP_SUBROUTINE_EXIT_IMM |=> ##1 acc == $past(instrImm, 2))
    else $error("exit immediate not loaded");
  a_interrupt_exit_sets_gie: assert property (s_take ##0 instrOp == OP_INTERRUPT_EXIT |=> ##1 globalInterruptEnable)
    else $error("interrupt exit left enable low");
  a_entry_vector: assert property (intAck |-> globalInterruptEnable && intPending && !instrReady
      ##1 pc == INT_VECTOR && !globalInterruptEnable)
    else $error("interrupt entry wrong");
  a_skip_acc_pc: assert property (s_take ##0 instrOp == OP_DECREMENT_SKIP_IF_ZERO_TO_ACC |=> ##1
      pc == $past(pc, 2) + ((acc == BYTE_ZERO) ? PC_SKIP_STEP : PC_STEP))
    else $error("skip step wrong");
endmodule
bind mcu_instruction_execute_subset exec_subset_asserts i_chk (
  .core_clk(core_clk), .resetn(resetn), .instrValid(instrValid), .instrReady(instrReady),
  .instrOp(instrOp), .instrImm(instrImm), .instrTarget(instrTarget), .intPending(intPending),
  .intAck(intAck), .pc(pc), .acc(acc), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
  .globalInterruptEnable(globalInterruptEnable));
`default_nettype wire

// >>> mcu_instruction_execute_subset.sv
// Purpose: 8-bit instruction execute subset
// Assumes: valid/ready instruction handshake
// Notes:   two clocks per instruction cycle
//
// Behaviour
// RULE_01: acc takes memory plus one; zero only.
// RULE_02: jump loads pc, two cycles.
// RULE_03: copies change no flag.
// RULE_04: idle changes nothing.
// RULE_05: OR into acc or memory; zero only.
// RULE_06: exit pops pc.
// RULE_07: exit with immediate loads acc.
// RULE_08: interrupt exit pops pc, sets enable.
// RULE_09: left rotate, bit 7 into bit 0.
// RULE_10: left rotate through carry.
// RULE_11: right rotate, bit 0 into bit 7.
// RULE_12: right rotate through carry.
// RULE_13: borrow subtract sets C OV Z AC.
// RULE_14: decrement-skip to memory.
// RULE_15: decrement-skip to acc.
// RULE_16: set-byte writes all ones.
// RULE_17: set-bit forces one bit.
// RULE_18: increment-skip to memory.
// RULE_19: taken skip two cycles, else one.
// RULE_20: others take one cycle; the three exits here take two, like jump.
`timescale 1ns/100ps
`default_nettype none
module mcu_instruction_execute_subset
  import mcu_exec_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  input  wire logic                    instrValid,
  output logic                         instrReady,
  input  wire mcu_exec_pkg::op_type    instrOp,
  input  wire logic [mcu_exec_pkg::RAM_AW-1:0]    instrAddr,
  input  wire logic [mcu_exec_pkg::DATA_W-1:0]    instrImm,
  input  wire logic [mcu_exec_pkg::PC_W-1:0]      instrTarget,
  input  wire logic [mcu_exec_pkg::BIT_SEL_W-1:0] instrBit,
  input  wire logic                    intPending,
  output logic                         intAck,
  output logic [mcu_exec_pkg::PC_W-1:0]   pc,
  output logic [mcu_exec_pkg::DATA_W-1:0] acc,
  output logic                         carryFlag,
  output logic                         zeroFlag,
  output logic                         auxCarryFlag,
  output logic                         overflowFlag,
  output logic                         globalInterruptEnable
);
  import mcu_exec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // rotate one place; returns {carry out, result}
  function automatic logic [DATA_W:0] rotateByte(input logic [DATA_W-1:0] val,
                                                 input logic left,
                                                 input logic thruCarry,
                                                 input logic cin);
    logic inBit;
    logic outBit;
    if (left) begin
      outBit = val[MSB];
      inBit  = thruCarry ? cin : val[MSB];
      rotateByte = {outBit, val[MSB-1:0], inBit};
    end else begin
      outBit = val[0];
      inBit  = thruCarry ? cin : val[0];
      rotateByte = {outBit, inBit, val[MSB:1]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  state_type         state_reg, state_next;
  op_type            op_reg, op_next;
  logic [RAM_AW-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] imm_reg, imm_next;
  logic [PC_W-1:0]   target_reg, target_next;
  logic [BIT_SEL_W-1:0] bit_reg, bit_next;
  logic [PC_W-1:0]   pc_next;
  logic [DATA_W-1:0] acc_next;
  logic              carry_next, zero_next, aux_next, ovf_next, gie_next;

  logic [DATA_W-1:0] memData;
  logic [PC_W-1:0]   stackTop;
  logic              ramWrEn;
  logic [DATA_W-1:0] ramWrData;
  logic              stackPush, stackPop;
  logic              intTake;

  logic [DATA_W:0]   rotResult;
  logic [DATA_W:0]   subWide;
  logic [NIB:0]      subNibble;
  logic [DATA_W-1:0] incByte, decByte;
  logic              branch, skip;

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  exec_data_ram u_ram (
    .core_clk (core_clk),
    .resetn   (resetn),
    .rdAddr   (instrAddr),
    .rdData   (memData),
    .wrEn     (ramWrEn),
    .wrAddr   (addr_reg),
    .wrData   (ramWrData)
  );

  exec_stack u_stack (
    .core_clk (core_clk),
    .resetn   (resetn),
    .push     (stackPush),
    .pop      (stackPop),
    .pushData (pc),
    .top      (stackTop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shared datapath terms

  // RULE_13 borrow subtract arithmetic
  assign subWide   = {1'b0, acc} - {1'b0, memData} - {{DATA_W{1'b0}}, ~carryFlag};
  assign subNibble = {1'b0, acc[NIB-1:0]} - {1'b0, memData[NIB-1:0]}
                     - {{NIB{1'b0}}, ~carryFlag};
  assign incByte   = memData + BYTE_ONE;
  assign decByte   = memData - BYTE_ONE;

  // a pending interrupt beats a new instruction while globalInterruptEnable is set
  assign intTake    = (state_reg == S_READY) && globalInterruptEnable && intPending;
  assign instrReady = (state_reg == S_READY) && !intTake;
  assign intAck     = intTake;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_next  = state_reg;
    op_next     = op_reg;
    addr_next   = addr_reg;
    imm_next    = imm_reg;
    target_next = target_reg;
    bit_next    = bit_reg;
    pc_next     = pc;
    acc_next    = acc;
    carry_next  = carryFlag;
    zero_next   = zeroFlag;
    aux_next    = auxCarryFlag;
    ovf_next    = overflowFlag;
    gie_next    = globalInterruptEnable;
    ramWrEn     = 1'b0;
    ramWrData   = BYTE_ZERO;
    stackPush   = 1'b0;
    stackPop    = 1'b0;
    branch      = 1'b0;
    skip        = 1'b0;
    rotResult   = rotateByte(memData, op_reg[2], op_reg[1], carryFlag);
    case (state_reg)
      S_READY: begin
        // RULE_08 pending interrupt entered first
        if (intTake) begin
          stackPush  = 1'b1;
          pc_next    = INT_VECTOR;
          gie_next   = 1'b0;
          state_next = S_DUMMY_A;
        end else if (instrValid) begin
          op_next     = instrOp;
          addr_next   = instrAddr;
          imm_next    = instrImm;
          target_next = instrTarget;
          bit_next    = instrBit;
          state_next  = S_EXEC;
        end
      end
      S_EXEC: begin
        case (op_reg)
          // RULE_04 idle changes nothing
          OP_IDLE_CYCLE: begin
          end
          // RULE_01 increment into acc
          OP_INCREMENT_TO_ACC: begin
            acc_next  = incByte;
            zero_next = (incByte == BYTE_ZERO);
          end
          // RULE_02 load jump target
          OP_JUMP_ABSOLUTE: begin
            pc_next = target_reg;
            branch  = 1'b1;
          end
          // RULE_03 copy forms, flags kept
          OP_COPY_MEM_TO_ACC: acc_next = memData;
          OP_COPY_IMM_TO_ACC: acc_next = imm_reg;
          OP_COPY_ACC_TO_MEM: begin
            ramWrEn   = 1'b1;
            ramWrData = acc;
          end
          // RULE_05 OR forms, zero only
          OP_OR_MEM_TO_ACC: begin
            acc_next  = acc | memData;
            zero_next = ((acc | memData) == BYTE_ZERO);
          end
          OP_OR_IMM_TO_ACC: begin
            acc_next  = acc | imm_reg;
            zero_next = ((acc | imm_reg) == BYTE_ZERO);
          end
          OP_DISJUNCTION_INTO_RAM: begin
            ramWrEn   = 1'b1;
            ramWrData = acc | memData;
            zero_next = ((acc | memData) == BYTE_ZERO);
          end
          // RULE_06 pop return address
          OP_SUBROUTINE_EXIT: begin
            stackPop = 1'b1;
            pc_next  = stackTop;
            branch   = 1'b1;
          end
          // RULE_07 pop and load immediate
          OP_SUBROUTINE_EXIT_IMM: begin
            stackPop = 1'b1;
            pc_next  = stackTop;
            acc_next = imm_reg;
            branch   = 1'b1;
          end
          // RULE_08 pop and re-enable
          OP_INTERRUPT_EXIT: begin
            stackPop = 1'b1;
            pc_next  = stackTop;
            gie_next = 1'b1;
            branch   = 1'b1;
          end
          // RULE_09 RULE_11 plain rotates to memory
          OP_ROTATE_LEFT_IN_PLACE, OP_ROTATE_RIGHT_IN_PLACE: begin
            ramWrEn   = 1'b1;
            ramWrData = rotResult[DATA_W-1:0];
          end
          // RULE_09 RULE_11 plain rotates to acc
          OP_ROTATE_LEFT_TO_ACC, OP_ROTATE_RIGHT_TO_ACC: begin
            acc_next = rotResult[DATA_W-1:0];
          end
          // RULE_10 RULE_12 carry rotates to memory
          OP_CARRY_ROTATE_LEFT, OP_CARRY_ROTATE_RIGHT: begin
            ramWrEn    = 1'b1;
            ramWrData  = rotResult[DATA_W-1:0];
            carry_next = rotResult[DATA_W];
          end
          // RULE_10 RULE_12 carry rotates to acc
          OP_CARRY_ROTATE_LEFT_TO_ACC, OP_CARRY_ROTATE_RIGHT_TO_ACC: begin
            acc_next   = rotResult[DATA_W-1:0];
            carry_next = rotResult[DATA_W];
          end
          // RULE_13 subtract with borrow, both forms
          OP_BORROW_SUBTRACT, OP_BORROW_SUBTRACT_TO_RAM: begin
            if (op_reg == OP_BORROW_SUBTRACT_TO_RAM) begin
              ramWrEn   = 1'b1;
              ramWrData = subWide[DATA_W-1:0];
            end else begin
              acc_next = subWide[DATA_W-1:0];
            end
            carry_next = ~subWide[DATA_W];
            aux_next   = ~subNibble[NIB];
            zero_next  = (subWide[DATA_W-1:0] == BYTE_ZERO);
            ovf_next   = (acc[MSB] ^ memData[MSB]) & (acc[MSB] ^ subWide[MSB]);
          end
          // RULE_14 decrement to memory, skip on zero
          OP_DECREMENT_SKIP_IF_ZERO: begin
            ramWrEn   = 1'b1;
            ramWrData = decByte;
            skip      = (decByte == BYTE_ZERO);
          end
          // RULE_15 decrement to acc, memory kept
          OP_DECREMENT_SKIP_IF_ZERO_TO_ACC: begin
            acc_next = decByte;
            skip     = (decByte == BYTE_ZERO);
          end
          // RULE_18 increment to memory, skip on zero
          OP_INCREMENT_SKIP_IF_ZERO: begin
            ramWrEn   = 1'b1;
            ramWrData = incByte;
            skip      = (incByte == BYTE_ZERO);
          end
          OP_INCREMENT_SKIP_IF_ZERO_TO_ACC: begin
            acc_next = incByte;
            skip     = (incByte == BYTE_ZERO);
          end
          // RULE_16 all ones
          OP_SET_BYTE: begin
            ramWrEn   = 1'b1;
            ramWrData = BYTE_ALL_ONES;
          end
          // RULE_17 force one bit
          OP_SET_BIT: begin
            ramWrEn   = 1'b1;
            ramWrData = memData | (BYTE_ONE << bit_reg);
          end
          default: begin
          end
        endcase
        // RULE_19 taken skip adds a dummy cycle
        if (!branch) begin
          pc_next = pc + (skip ? PC_SKIP_STEP : PC_STEP);
        end
        // RULE_20 plain ops ready at once
        state_next = (branch || skip) ? S_DUMMY_A : S_READY;
      end
      // RULE_02 RULE_19 dummy instruction cycle
      S_DUMMY_A: state_next = S_DUMMY_B;
      S_DUMMY_B: state_next = S_READY;
      default:   state_next = S_READY;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg             <= S_READY;
      op_reg                <= OP_IDLE_CYCLE;
      addr_reg              <= '0;
      imm_reg               <= BYTE_ZERO;
      target_reg            <= PC_RESET;
      bit_reg               <= '0;
      pc                    <= PC_RESET;
      acc                   <= BYTE_ZERO;
      carryFlag             <= 1'b0;
      zeroFlag              <= 1'b0;
      auxCarryFlag          <= 1'b0;
      overflowFlag          <= 1'b0;
      globalInterruptEnable <= 1'b0;
    end else begin
      state_reg             <= state_next;
      op_reg                <= op_next;
      addr_reg              <= addr_next;
      imm_reg               <= imm_next;
      target_reg            <= target_next;
      bit_reg               <= bit_next;
      pc                    <= pc_next;
      acc                   <= acc_next;
      carryFlag             <= carry_next;
      zeroFlag              <= zero_next;
      auxCarryFlag          <= aux_next;
      overflowFlag          <= ovf_next;
      globalInterruptEnable <= gie_next;
    end
  end

endmodule
`default_nettype wire

// >>> mcu_instruction_execute_subset_tb.sv
// Purpose: random stream against a model
// Assumes: words 0..3 written first
// Notes:   memory seen via acc
`timescale 1ns/100ps
`default_nettype none
module mcu_instruction_execute_subset_tb;
  import mcu_exec_pkg::*;
  logic                 core_clk, resetn, instrValid, raise, instrReady, intPending, intAck;
  logic                 carryFlag, zeroFlag, auxCarryFlag, overflowFlag, globalInterruptEnable;
  op_type               instrOp;
  logic [RAM_AW-1:0]    instrAddr;
  logic [DATA_W-1:0]    instrImm, acc;
  logic [PC_W-1:0]      instrTarget, pc;
  logic [BIT_SEL_W-1:0] instrBit;
  logic [31:0]          seed = 32'h0000_0034;
  logic [31:0]          r;
  int                   error_cnt, num_checks, cycles, mAcc, mPc, mC, mZ, mAc, copy_transfer, mGie, pend, sp;
  int                   ram[4];
  int                   stk[8];
  mcu_instruction_execute_subset i_dut (.core_clk(core_clk), .resetn(resetn),
    .instrValid(instrValid), .instrReady(instrReady), .instrOp(instrOp), .instrAddr(instrAddr),
    .instrImm(instrImm), .instrTarget(instrTarget), .instrBit(instrBit), .intPending(intPending),
    .intAck(intAck), .pc(pc), .acc(acc), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
    .auxCarryFlag(auxCarryFlag), .overflowFlag(overflowFlag),
    .globalInterruptEnable(globalInterruptEnable));
  irq_source_model i_irq (.core_clk(core_clk), .resetn(resetn), .raise(raise), .intAck(intAck),
    .intPending(intPending));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // interrupt entry model
  task automatic enter();
    if (pend && mGie) begin
      stk[sp] = mPc;
      sp = (sp + 1) % 8;
      mPc = INT_VECTOR;
      mGie = 0;
      pend = 0;
    end
  endtask
  task automatic model(op_type op, int a, int imm, int tgt, int b);
    int m, t, nb, s;
    m = ram[a];
    nb = 1 - mC;
    s = $signed(8'(mAcc)) - $signed(8'(m)) - nb;
    case (op)
      OP_INCREMENT_TO_ACC, OP_INCREMENT_SKIP_IF_ZERO, OP_INCREMENT_SKIP_IF_ZERO_TO_ACC: t = m + 1;
      OP_DECREMENT_SKIP_IF_ZERO, OP_DECREMENT_SKIP_IF_ZERO_TO_ACC: t = m + 255;
      OP_COPY_MEM_TO_ACC: t = m;
      OP_COPY_IMM_TO_ACC, OP_SUBROUTINE_EXIT_IMM: t = imm;
      OP_OR_MEM_TO_ACC, OP_DISJUNCTION_INTO_RAM: t = mAcc | m;
      OP_OR_IMM_TO_ACC: t = mAcc | imm;
      OP_ROTATE_LEFT_IN_PLACE, OP_ROTATE_LEFT_TO_ACC: t = (m << 1) | (m >> 7);
      OP_CARRY_ROTATE_LEFT, OP_CARRY_ROTATE_LEFT_TO_ACC: t = (m << 1) | mC;
      OP_ROTATE_RIGHT_IN_PLACE, OP_ROTATE_RIGHT_TO_ACC: t = (m >> 1) | ((m % 2) << 7);
      OP_CARRY_ROTATE_RIGHT, OP_CARRY_ROTATE_RIGHT_TO_ACC: t = (m >> 1) | (mC << 7);
      OP_BORROW_SUBTRACT, OP_BORROW_SUBTRACT_TO_RAM: t = mAcc - m - nb;
      OP_SET_BYTE: t = 255;
      OP_SET_BIT: t = m | (1 << b);
      default: t = mAcc;
    endcase
    if (op inside {OP_BORROW_SUBTRACT, OP_BORROW_SUBTRACT_TO_RAM}) begin
      mC = t >= 0;
      mAc = (mAcc % 16) - (m % 16) - nb >= 0;
      copy_transfer = s < -128 || s > 127;
    end
    // carry from the bit shifted out
    if (op inside {OP_CARRY_ROTATE_LEFT, OP_CARRY_ROTATE_LEFT_TO_ACC}) mC = m / 128;
    if (op inside {OP_CARRY_ROTATE_RIGHT, OP_CARRY_ROTATE_RIGHT_TO_ACC}) mC = m % 2;
    t = t & 255;
    if (op inside {OP_INCREMENT_TO_ACC, [OP_OR_MEM_TO_ACC:OP_DISJUNCTION_INTO_RAM],
                   OP_BORROW_SUBTRACT, OP_BORROW_SUBTRACT_TO_RAM}) mZ = t == 0;
    if (op inside {OP_COPY_ACC_TO_MEM, OP_DISJUNCTION_INTO_RAM, OP_BORROW_SUBTRACT_TO_RAM,
                   OP_DECREMENT_SKIP_IF_ZERO, OP_INCREMENT_SKIP_IF_ZERO, OP_SET_BYTE, OP_SET_BIT}
        || (op inside {[OP_ROTATE_LEFT_IN_PLACE:OP_CARRY_ROTATE_RIGHT_TO_ACC]} && !op[0]))
      ram[a] = t;
    else mAcc = t;
    mPc = (mPc + 1 + int'(op inside {[OP_DECREMENT_SKIP_IF_ZERO:OP_INCREMENT_SKIP_IF_ZERO_TO_ACC]}
          && t == 0)) % 2048;
    if (op == OP_JUMP_ABSOLUTE) mPc = tgt;
    if (op inside {[OP_SUBROUTINE_EXIT:OP_INTERRUPT_EXIT]}) begin
      sp = (sp + 7) % 8;
      mPc = stk[sp];
    end
    if (op == OP_INTERRUPT_EXIT) mGie = 1;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (instrReady !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n == 20) error_cnt++;
  endtask
  task automatic raise_irq();
    raise = 1'b1;
    @(posedge core_clk);
    #1 raise = 1'b0;
    pend = 1;
  endtask
  task automatic run(op_type op, int a, int imm);
    logic [31:0] w;
    w = rnd();
    enter();
    wait_ready();
    instrValid = 1'b1;
    instrOp = op;
    instrAddr = 8'(a);
    instrImm = 8'(imm);
    instrTarget = w[PC_W-1:0];
    instrBit = w[13:11];
    @(posedge core_clk);
    #1 instrValid = 1'b0;
    model(op, a, imm, int'(instrTarget), int'(instrBit));
    enter();
    wait_ready();
    check("acc", acc, mAcc);
    check("pc", pc, mPc);
    check("carry", carryFlag, mC);
    check("zero", zeroFlag, mZ);
    check("auxcarry", auxCarryFlag, mAc);
    check("overflow", overflowFlag, copy_transfer);
    check("gie", globalInterruptEnable, mGie);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    resetn = 1'b0;
    instrValid = 1'b0;
    raise = 1'b0;
    instrOp = OP_IDLE_CYCLE;
    instrAddr = '0;
    instrImm = '0;
    instrTarget = '0;
    instrBit = '0;
    repeat (2) @(posedge core_clk);
    #1 resetn = 1'b1;
    check("ready", instrReady, 1);
    check("pc", pc, 0);
    // seed words 0..3 so later reads are defined
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      run(OP_COPY_IMM_TO_ACC, 0, r[7:0]);
      run(OP_COPY_ACC_TO_MEM, i, 0);
    end
    repeat (300) begin
      r = rnd();
      if (r[3:0] == 4'h0) raise_irq();
      run(op_type'(5'(r[31:16] % 28)), r[5:4], r[15:8]);
    end
    raise_irq();
    run(OP_INTERRUPT_EXIT, 0, 0);
    results();
  end
endmodule
`default_nettype wire
